// [verilog/hbf_pkg.sv]
// constants for the high bus fault response select block
package hbf_pkg;
  localparam int          NUM_FAULTS       = 3;
  localparam logic [7:0]  CTRL_ADDR        = 8'hb8;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [7:0]  STATUS_ADDR      = 8'hd7;
  localparam logic [7:0]  ENABLE_ADDR      = 8'hb0;
  localparam int          ENABLE_BIT       = 7;
  // field lsb per fault: out uv, in ov, in uv
  localparam int          FIELD_LSB [3]    = '{2, 4, 6};
  localparam int          STATUS_BIT [3]   = '{5, 6, 7};
  localparam logic [1:0]  RESP_FLAG        = 2'h0;
  localparam logic [1:0]  RESP_HICCUP      = 2'h1;
  localparam logic [1:0]  RESP_LATCH       = 2'h2;
  localparam logic [1:0]  RESP_FLAG_ALT    = 2'h3;
  localparam longint      CLK_HZ           = 200000000;
  localparam longint      HICCUP_DELAY_MS  = 500;
  localparam longint      HICCUP_CYCLES    = HICCUP_DELAY_MS * CLK_HZ / 1000;
  typedef enum logic [1:0] {HBF_RUN, HBF_HICCUP, HBF_LATCHED} hbf_state_t;
endpackage : hbf_pkg

// [verilog/hbf_channel.sv]
// one fault channel: response state and hiccup restart timer
`timescale 1ns/1ps
module hbf_channel #(
  parameter int unsigned DELAY_CYCLES = 100000000,
  parameter int unsigned CW           = 27
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       fault,
  input  wire logic [1:0] resp,
  input  wire logic       restart,
  output logic            stop
);
  import hbf_pkg::*;
  hbf_state_t state;
  logic [CW-1:0] cnt;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= HBF_RUN;
      cnt   <= '0;
    end else begin
      unique case (state)
        HBF_RUN: begin
          cnt <= '0;
          if (fault && resp == RESP_HICCUP) state <= HBF_HICCUP;
          else if (fault && resp == RESP_LATCH) state <= HBF_LATCHED;
        end
        HBF_HICCUP: begin
          if (fault) cnt <= '0;
          else if (cnt == CW'(DELAY_CYCLES - 1)) begin
            state <= HBF_RUN;
            cnt   <= '0;
          end else cnt <= cnt + 1'b1;
        end
        HBF_LATCHED: begin
          if (restart && !fault) state <= HBF_RUN;
        end
      endcase
    end
  end

  assign stop = (state != HBF_RUN);
endmodule : hbf_channel

// [verilog/hbf_top.sv]
// high bus fault response select: control register, status, switching gate
// Contract
// - enable bit set: each fault uses its own two-bit control field.
// - enable bit clear: fields ignored, mode pin setting chooses every response.
// - 00 or 11 flags only: status set, status pin low, switching continues.
// - hiccup and latch-off stop switching as status is set.
// - hiccup restarts switching after fault absent for the restart delay.
// - latch-off stays stopped until switching or chip enable is toggled.
// - bits 3:2 pick output undervoltage response; sets status bit 5.
// - bits 5:4 pick input overvoltage response; sets status bit 6.
// - bits 7:6 pick input undervoltage response; sets status bit 7.
`timescale 1ns/1ps
module hbf_top #(
  parameter int unsigned HICCUP_DELAY = int'(hbf_pkg::HICCUP_CYCLES)
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       indiv_resp_en,
  input  wire logic [1:0] mode_pin_resp,
  input  wire logic       out_uv_fault,
  input  wire logic       in_ov_fault,
  input  wire logic       in_uv_fault,
  input  wire logic       switch_en,
  input  wire logic       chip_en,
  output logic            switch_allow,
  output logic            fault_status_out_n
);
  import hbf_pkg::*;

  localparam int unsigned CW = $clog2(HICCUP_DELAY + 1);

  // register map
  logic [7:0]            high_bus_fault_response_ctrl;
  logic [7:0]            fault_status;
  logic [NUM_FAULTS-1:0] status_bits;
  logic                  ctrl_wr;
  logic                  status_wr;

  // synchronised pin inputs
  logic [NUM_FAULTS-1:0] raw_s1;
  logic [NUM_FAULTS-1:0] raw_s2;
  logic [1:0]            mode_s1;
  logic [1:0]            mode_s2;
  logic                  en_s1;
  logic                  en_s2;
  logic                  sw_s1;
  logic                  sw_s2;
  logic                  sw_d;
  logic                  ce_s1;
  logic                  ce_s2;
  logic                  ce_d;

  // response selection and switching gate
  logic [1:0]            resp_sel [NUM_FAULTS];
  logic [NUM_FAULTS-1:0] stop_now;
  logic [NUM_FAULTS-1:0] stop_vec;
  logic                  restart;

  // fault comparator levels through two flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      raw_s1 <= '0;
      raw_s2 <= '0;
    end else begin
      raw_s1 <= {in_uv_fault, in_ov_fault, out_uv_fault};
      raw_s2 <= raw_s1;
    end
  end

  // response source select and mode code through two flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_s1 <= '0;
      mode_s2 <= '0;
      en_s1   <= 1'b0;
      en_s2   <= 1'b0;
    end else begin
      mode_s1 <= mode_pin_resp;
      mode_s2 <= mode_s1;
      en_s1   <= indiv_resp_en;
      en_s2   <= en_s1;
    end
  end

  // switching enable; resets high so no false edge follows reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sw_s1 <= 1'b1;
      sw_s2 <= 1'b1;
      sw_d  <= 1'b1;
    end else begin
      sw_s1 <= switch_en;
      sw_s2 <= sw_s1;
      sw_d  <= sw_s2;
    end
  end

  // chip enable; resets high so no false edge follows reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ce_s1 <= 1'b1;
      ce_s2 <= 1'b1;
      ce_d  <= 1'b1;
    end else begin
      ce_s1 <= chip_en;
      ce_s2 <= ce_s1;
      ce_d  <= ce_s2;
    end
  end

  // a toggle (fall then rise) re-arms; rising edge of either enable
  assign restart = (sw_s2 && !sw_d) || (ce_s2 && !ce_d);

  // register strobes
  assign ctrl_wr   = reg_wr && (reg_addr == CTRL_ADDR);
  assign status_wr = reg_wr && (reg_addr == STATUS_ADDR);

  // control register write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      high_bus_fault_response_ctrl <= CTRL_RESET;
    end else if (ctrl_wr) begin
      high_bus_fault_response_ctrl <= reg_wdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_FAULTS; g++) begin : g_ch
      logic [1:0] field;
      assign field       = high_bus_fault_response_ctrl[FIELD_LSB[g] +: 2];
      assign resp_sel[g] = en_s2 ? field : mode_s2;
      // stop request in the same cycle the status bit is set
      assign stop_now[g] = raw_s2[g]
                           && (resp_sel[g] == RESP_HICCUP || resp_sel[g] == RESP_LATCH);

      hbf_channel #(
        .DELAY_CYCLES (HICCUP_DELAY),
        .CW           (CW)
      ) u_ch (
        .clk     (clk),
        .nrst    (nrst),
        .fault   (raw_s2[g]),
        .resp    (resp_sel[g]),
        .restart (restart),
        .stop    (stop_vec[g])
      );

      // sticky status, set wins over clear-on-write
      always_ff @(posedge clk) begin
        if (!nrst) begin
          status_bits[g] <= 1'b0;
        end else if (raw_s2[g]) begin
          status_bits[g] <= 1'b1;
        end else if (status_wr && reg_wdata[STATUS_BIT[g]]) begin
          status_bits[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // place status bits at their register positions, others read zero
  always_comb begin
    fault_status = '0;
    for (int i = 0; i < NUM_FAULTS; i++) begin
      fault_status[STATUS_BIT[i]] = status_bits[i];
    end
  end

  // status pin low with the status bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_status_out_n <= 1'b1;
    end else begin
      fault_status_out_n <= ~(|status_bits | |raw_s2);
    end
  end

  // switching stops with the status bit for hiccup and latch-off
  always_ff @(posedge clk) begin
    if (!nrst) begin
      switch_allow <= 1'b1;
    end else begin
      switch_allow <= ~(|stop_vec | |stop_now);
    end
  end

  // registered read data, holds until the next read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CTRL_ADDR: begin
          reg_rdata <= high_bus_fault_response_ctrl;
        end
        STATUS_ADDR: begin
          reg_rdata <= fault_status;
        end
        default: begin
          reg_rdata <= '0;
        end
      endcase
    end
  end
endmodule : hbf_top

// [dv/hbf_monitor.sv]
// assertions on the fault response select ports
`timescale 1ns/1ps
module hbf_monitor #(parameter int unsigned HICCUP_DELAY = 20) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       indiv_resp_en,
  input wire logic [1:0] mode_pin_resp,
  input wire logic       out_uv_fault,
  input wire logic       in_ov_fault,
  input wire logic       in_uv_fault,
  input wire logic       switch_allow,
  input wire logic       fault_status_out_n
);
  logic [7:0] ctrl;
  logic [2:0] f;
  logic [2:0] stp;
  assign f = {in_uv_fault, in_ov_fault, out_uv_fault};
  always_ff @(posedge clk)
    if (!nrst) ctrl <= 8'h00;
    else if (reg_wr && reg_addr == 8'hb8) ctrl <= reg_wdata;
  // fault present with a response that stops switching
  for (genvar i = 0; i < 3; i++) begin : g_stp
    assign stp[i] = f[i] && ^(indiv_resp_en ? ctrl[2*i+3-:2] : mode_pin_resp);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_trip(s);
    $rose(s) ##1 s [*2];
  endsequence
  a_flag_low: assert property (s_trip(|f) |=> !fault_status_out_n) else $error("no flag");
  a_ouv_stop: assert property (s_trip(stp[0]) |=> !switch_allow) else $error("no stop");
  a_iov_stop: assert property (s_trip(stp[1]) |=> !switch_allow) else $error("no stop");
  a_iuv_stop: assert property (s_trip(stp[2]) |=> !switch_allow) else $error("no stop");
  a_stop_cause: assert property ($fell(switch_allow) |-> $past(|stp, 3)) else $error("stray");
  a_rd_ctrl: assert property (reg_rd && reg_addr == 8'hb8 |=> reg_rdata == $past(ctrl))
    else $error("ctrl read");
  a_rd_unmap: assert property (reg_rd && reg_addr != 8'hb8 && reg_addr != 8'hd7
    |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_rd_stat: assert property (reg_rd && reg_addr == 8'hd7 |=> reg_rdata[4:0] == 5'h00)
    else $error("status low bits");
endmodule : hbf_monitor
bind hbf_top hbf_monitor #(.HICCUP_DELAY(HICCUP_DELAY)) mon_u (.clk(clk), .nrst(nrst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .indiv_resp_en(indiv_resp_en), .mode_pin_resp(mode_pin_resp),
  .out_uv_fault(out_uv_fault), .in_ov_fault(in_ov_fault), .in_uv_fault(in_uv_fault),
  .switch_allow(switch_allow), .fault_status_out_n(fault_status_out_n));

// [dv/hbf_top_tb_top.sv]
// testbench for the fault response select block
`timescale 1ns/1ps
module hbf_top_tb_top;
  import hbf_pkg::*;
  logic       clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, ind = 1, sw_en = 1, ch_en = 1;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [1:0] mode = 0;
  logic [2:0] f = 0;
  logic       sa, fs_n;
  int         failures = 0, n_compared = 0;
  hbf_top #(.HICCUP_DELAY(20)) dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .indiv_resp_en(ind), .mode_pin_resp(mode), .out_uv_fault(f[0]), .in_ov_fault(f[1]),
    .in_uv_fault(f[2]), .switch_en(sw_en), .chip_en(ch_en), .switch_allow(sa),
    .fault_status_out_n(fs_n));
  task automatic results;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(logic w, logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
    @(posedge clk);
  endtask : acc
  task automatic tk(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tk
  task automatic wait_sa(int n);
    repeat (n) begin
      @(negedge clk);
      if (sa === 1'b1) return;
    end
    failures++;
    results();
  endtask : wait_sa
  task automatic t_reg;
    acc(0, CTRL_ADDR, 0);
    chk("ctrl reset", CTRL_RESET, reg_rdata);
    acc(1, CTRL_ADDR, 8'ha5);
    acc(0, CTRL_ADDR, 0);
    chk("ctrl", 8'ha5, reg_rdata);
    acc(0, 8'h10, 0);
    chk("unmapped", 8'h00, reg_rdata);
  endtask : t_reg
  task automatic t_codes;
    int i;
    for (int c = 0; c < 4; c++) begin
      i = c % 3;
      acc(1, CTRL_ADDR, 8'(c << FIELD_LSB[i]));
      @(posedge clk);
      f[i] <= 1;
      tk(5);
      chk("allow", 8'(c != 1 && c != 2), 8'(sa));
      chk("flag", 8'h00, 8'(fs_n));
      acc(0, STATUS_ADDR, 0);
      chk("status", 8'(1 << STATUS_BIT[i]), reg_rdata);
      @(posedge clk);
      f[i] <= 0;
      tk(4);
      if (c == 1) begin
        tk(8);
        @(posedge clk);
        f[i] <= 1;
        @(posedge clk);
        f[i] <= 0;
        tk(15);
        chk("hiccup hold", 8'h00, 8'(sa));
        wait_sa(40);
      end
      if (c == 2) begin
        tk(40);
        chk("latched", 8'h00, 8'(sa));
        @(posedge clk);
        sw_en <= 0;
        tk(2);
        @(posedge clk);
        sw_en <= 1;
        wait_sa(10);
      end
      acc(1, STATUS_ADDR, 8'hff);
      tk(3);
      chk("flag clear", 8'h01, 8'(fs_n));
    end
  endtask : t_codes
  task automatic t_mode;
    @(posedge clk);
    ind <= 0;
    mode <= RESP_LATCH;
    tk(4);
    @(posedge clk);
    f[0] <= 1;
    tk(5);
    chk("mode stop", 8'h00, 8'(sa));
    @(posedge clk);
    f[0] <= 0;
    tk(6);
    @(posedge clk);
    ch_en <= 0;
    tk(2);
    @(posedge clk);
    ch_en <= 1;
    wait_sa(10);
  endtask : t_mode
  initial forever #2.5 clk = ~clk;
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1;
    t_reg();
    t_codes();
    t_mode();
    results();
  end
endmodule : hbf_top_tb_top
